// ===== uif_pkg.sv
// package for the usb interrupt status funnel
// assumes a 10 MHz pclk and an apb register bus with 32-bit data
package uif_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, printed offsets are indices)
  // ------------------------------------------------------------
  localparam logic [11:0] UIF_IDX_FLAGS    = 12'h0f62;
  localparam logic [11:0] UIF_IDX_ENABLES  = 12'h0f36;
  localparam logic [11:0] UIF_IDX_ERRFLAGS = 12'h0f63;
  localparam logic [11:0] UIF_IDX_ERRENS   = 12'h0f37;
  localparam logic [11:0] UIF_IDX_CONTROL  = 12'h0f65;
  localparam logic [11:0] UIF_IDX_ADDRESS  = 12'h0f6e;
  localparam logic [13:0] UIF_ADDR_FLAGS    = {UIF_IDX_FLAGS, 2'b00};
  localparam logic [13:0] UIF_ADDR_ENABLES  = {UIF_IDX_ENABLES, 2'b00};
  localparam logic [13:0] UIF_ADDR_ERRFLAGS = {UIF_IDX_ERRFLAGS, 2'b00};
  localparam logic [13:0] UIF_ADDR_ERRENS   = {UIF_IDX_ERRENS, 2'b00};
  localparam logic [13:0] UIF_ADDR_CONTROL  = {UIF_IDX_CONTROL, 2'b00};
  localparam logic [13:0] UIF_ADDR_ADDRESS  = {UIF_IDX_ADDRESS, 2'b00};

  // ------------------------------------------------------------
  // field positions of the top-level flags, the control suspend bit and the controller flag bit
  // ------------------------------------------------------------
  localparam int UIF_B_RESET = 0;
  localparam int UIF_B_ERR   = 1;
  localparam int UIF_B_ACTV  = 2;
  localparam int UIF_B_TRN   = 3;
  localparam int UIF_B_IDLE  = 4;
  localparam int UIF_B_STALL = 5;
  localparam int UIF_B_SOF   = 6;
  localparam int UIF_B_SUSP  = 1;
  localparam int UIF_IRQ_BIT = 4;

  // ------------------------------------------------------------
  // masks and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] UIF_FLAGS_RST   = 8'h00;
  localparam logic [7:0] UIF_SW_WR_MASK  = 8'h7d;
  localparam logic [7:0] UIF_EN_MASK     = 8'h7f;
  localparam logic [7:0] UIF_ERR_MASK    = 8'h9f;
  localparam logic [7:0] UIF_CTRL_MASK   = 8'h02;
  localparam logic [7:0] UIF_ADDR_MASK   = 8'h7f;
  localparam logic [6:0] UIF_ADDR_RST    = 7'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int UIF_CLK_HZ       = 10_000_000;
  localparam int UIF_IDLE_MS      = 3;
  localparam int UIF_IDLE_CYC     = UIF_IDLE_MS * (UIF_CLK_HZ / 1000);
  localparam int UIF_WAKE_SYNC    = 4;

endpackage

// ===== uif_evt_if.sv
// interface carrying engine events into the flag core
// assumes events are one-cycle pulses on pclk
`timescale 1ns/1ps
interface uif_evt_if;
  logic       sof;
  logic       stall;
  logic       idle;
  logic       trn;
  logic       actv;
  logic       rst;
  logic [7:0] err;
  modport src (output sof, stall, idle, trn, actv, rst, err);
  modport dst (input sof, stall, idle, trn, actv, rst, err);
endinterface

// ===== uif_idle_timer.sv
// idle detector: pulses after the bus has been idle long enough
// assumes bus_idle is already synchronised to pclk
`timescale 1ns/1ps
module uif_idle_timer
  import uif_pkg::*;
#(
  parameter int IDLE_CYC = UIF_IDLE_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bus state
  input  wire logic bus_idle,
  input  wire logic run,
  // event out
  output logic      idle_pulse
);

  logic [15:0] cnt_r;
  logic        fired_r;

  // count continuous idle; one pulse per idle stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 16'h0000;
      fired_r <= 1'b0;
    end else if (!bus_idle || !run) begin
      cnt_r   <= 16'h0000;
      fired_r <= !bus_idle ? 1'b0 : fired_r;
    end else if (cnt_r < 16'(IDLE_CYC - 1)) begin
      cnt_r <= cnt_r + 16'h0001;
    end else begin
      fired_r <= 1'b1;
    end
  end

  assign idle_pulse = run && bus_idle && !fired_r
                      && (cnt_r == 16'(IDLE_CYC - 1));

endmodule

// ===== uif_funnel.sv
// usb interrupt status funnel: flags, enables, error layer, apb slave
// assumes engine event pulses on pclk and asynchronous bus line levels
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module uif_funnel
  import uif_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // engine events, one-cycle pulses
  input  wire logic        ev_sof,
  input  wire logic        ev_stall,
  input  wire logic        ev_trn,
  input  wire logic        ev_reset,
  input  wire logic [7:0]  ev_err,
  // bus line levels and clock status, asynchronous
  input  wire logic        line_dp,
  input  wire logic        line_dm,
  input  wire logic        bus_idle,
  input  wire logic        pll_locked,
  // outputs to the system
  output logic             usb_combined_irq,
  output logic             engine_clk_en,
  output logic             queue_advance,
  output logic [6:0]       device_address
);

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= {pll_locked, bus_idle, line_dm, line_dp};
      s2_r <= s1_r;
    end
  end

  logic dp_s;
  logic dm_s;
  logic idle_s;
  logic lock_s;
  assign {lock_s, idle_s, dm_s, dp_s} = s2_r;

  // edge detector waits until the synchroniser holds real line levels,
  // otherwise the reset zeros would look like activity on an idle bus
  logic [1:0] prime_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prime_r <= 2'h0;
    end else if (!(&prime_r)) begin
      prime_r <= prime_r + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] en_r;
  logic [7:0] eflags_r;
  logic [7:0] eflags_nxt;
  logic [7:0] een_r;
  logic [7:0] ctrl_r;
  logic [6:0] addr_r;
  logic [2:0] wake_r;
  logic       armed_r;
  logic       dp_d_r;
  logic       dm_d_r;

  function automatic logic hit(input logic [31:0] a, input logic [13:0] b);
    return a[31:14] == 18'h0_0000 && a[13:0] == b;
  endfunction

  logic wr;
  logic rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  logic mapped;
  assign mapped = hit(paddr, UIF_ADDR_FLAGS) || hit(paddr, UIF_ADDR_ENABLES)
               || hit(paddr, UIF_ADDR_ERRFLAGS) || hit(paddr, UIF_ADDR_ERRENS)
               || hit(paddr, UIF_ADDR_CONTROL) || hit(paddr, UIF_ADDR_ADDRESS);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  logic w_flags;
  logic w_eflags;
  assign w_flags  = wr && hit(paddr, UIF_ADDR_FLAGS);
  assign w_eflags = wr && hit(paddr, UIF_ADDR_ERRFLAGS);

  // ------------------------------------------------------------
  // suspend, wake sync and event gating
  // ------------------------------------------------------------
  logic susp;
  logic run;
  assign susp = ctrl_r[UIF_B_SUSP];
  // pll lock also holds off the engine after wake
  assign run           = !susp && lock_s;
  assign engine_clk_en = run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= 3'h0;
    end else if (!run) begin
      wake_r <= 3'(UIF_WAKE_SYNC);
    end else if (wake_r != 3'h0) begin
      wake_r <= wake_r - 3'h1;
    end
  end

  logic actv_clr_ok;
  assign actv_clr_ok = run && wake_r == 3'h0;

  uif_evt_if evt ();
  logic idle_p;
  uif_idle_timer u_idle (
    .pclk       (pclk),
    .presetn    (presetn),
    .bus_idle   (idle_s),
    .run        (run),
    .idle_pulse (idle_p)
  );

  // only line activity passes while suspended
  assign evt.sof   = ev_sof && run;
  assign evt.stall = ev_stall && run;
  assign evt.trn   = ev_trn && run;
  assign evt.rst   = ev_reset && run;
  assign evt.err   = run ? ev_err & UIF_ERR_MASK : 8'h00;
  assign evt.idle  = idle_p;
  // activity is an edge on either line, armed once per idle
  assign evt.actv  = (&prime_r) && armed_r
                     && ((dp_s ^ dp_d_r) || (dm_s ^ dm_d_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_d_r  <= 1'b0;
      dm_d_r  <= 1'b0;
      armed_r <= 1'b1;
    end else begin
      dp_d_r <= dp_s;
      dm_d_r <= dm_s;
      if (evt.idle) begin
        armed_r <= 1'b1;
      end else if (evt.actv) begin
        armed_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // error layer
  // ------------------------------------------------------------
  always_comb begin
    eflags_nxt = eflags_r;
    if (w_eflags) begin
      eflags_nxt = eflags_r & pwdata[7:0];
    end
    eflags_nxt = (eflags_nxt | evt.err) & UIF_ERR_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eflags_r <= UIF_FLAGS_RST;
    end else begin
      eflags_r <= eflags_nxt;
    end
  end

  logic err_any;
  assign err_any = |(eflags_r & een_r);

  // ------------------------------------------------------------
  // top-level flags
  // ------------------------------------------------------------
  logic [7:0] hw_set;
  assign hw_set = {1'b0, evt.sof, evt.stall, evt.idle, evt.trn,
                   evt.actv, 1'b0, evt.rst};

  always_comb begin
    flags_nxt = flags_r;
    if (w_flags) begin
      // writes store zeros and ones alike on writable bits, but a set activity bit holds until wake sync ends
      flags_nxt = (flags_r & ~UIF_SW_WR_MASK)
                | (pwdata[7:0] & UIF_SW_WR_MASK);
      if (!actv_clr_ok && flags_r[UIF_B_ACTV]) begin
        flags_nxt[UIF_B_ACTV] = 1'b1;
      end
    end
    flags_nxt = flags_nxt | hw_set;
    flags_nxt[UIF_B_ERR] = err_any;
    flags_nxt[7]         = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= UIF_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // clearing the done flag pops the transfer status queue
  assign queue_advance = w_flags && flags_r[UIF_B_TRN]
                      && !pwdata[UIF_B_TRN] && !evt.trn;

  // ------------------------------------------------------------
  // enables, control, address
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r   <= UIF_FLAGS_RST;
      een_r  <= UIF_FLAGS_RST;
      ctrl_r <= UIF_FLAGS_RST;
    end else if (wr) begin
      if (hit(paddr, UIF_ADDR_ENABLES)) begin
        en_r <= pwdata[7:0] & UIF_EN_MASK;
      end
      if (hit(paddr, UIF_ADDR_ERRENS)) begin
        een_r <= pwdata[7:0] & UIF_ERR_MASK;
      end
      if (hit(paddr, UIF_ADDR_CONTROL)) begin
        ctrl_r <= pwdata[7:0] & UIF_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= UIF_ADDR_RST;
    end else if (evt.rst) begin
      addr_r <= UIF_ADDR_RST;
    end else if (wr && hit(paddr, UIF_ADDR_ADDRESS)) begin
      addr_r <= pwdata[6:0];
    end
  end
  assign device_address = addr_r;

  // ------------------------------------------------------------
  // request to the processor
  // ------------------------------------------------------------
  // registered so the request never glitches on a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_combined_irq <= 1'b0;
    end else begin
      usb_combined_irq <= |(flags_nxt & en_r);
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit(paddr, UIF_ADDR_FLAGS))    prdata[7:0] <= flags_r;
      if (hit(paddr, UIF_ADDR_ENABLES))  prdata[7:0] <= en_r;
      if (hit(paddr, UIF_ADDR_ERRFLAGS)) prdata[7:0] <= eflags_r;
      if (hit(paddr, UIF_ADDR_ERRENS))   prdata[7:0] <= een_r;
      if (hit(paddr, UIF_ADDR_CONTROL))  prdata[7:0] <= ctrl_r;
      if (hit(paddr, UIF_ADDR_ADDRESS))  prdata[6:0] <= addr_r;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_irq_follows_flags: assert property (@(posedge pclk) disable iff (!presetn)
    usb_combined_irq == |($past(flags_nxt) & $past(en_r)))
    else $error("irq does not follow enabled flags");
  a_err_flag_or: assert property (@(posedge pclk) disable iff (!presetn)
    flags_r[UIF_B_ERR] == |($past(eflags_r) & $past(een_r)))
    else $error("combined error flag wrong");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (flags_r[UIF_B_SOF] && !w_flags) |=> flags_r[UIF_B_SOF])
    else $error("frame flag dropped without write");
  a_sw_set_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (w_flags && pwdata[UIF_B_STALL]) |=> flags_r[UIF_B_STALL])
    else $error("software set ignored");
  a_suspend_gates: assert property (@(posedge pclk) disable iff (!presetn)
    (susp && ev_sof && !flags_r[UIF_B_SOF] && !w_flags) |=> !flags_r[UIF_B_SOF])
    else $error("frame flag set while suspended");
  a_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !flags_r[7])
    else $error("bit 7 set");
  a_stall_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (run && ev_stall) |=> flags_r[UIF_B_STALL])
    else $error("stall flag not set");
  a_reset_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (run && ev_reset) |=> (flags_r[UIF_B_RESET] && device_address == 7'h00))
    else $error("bus reset not handled");
  a_actv_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (susp && flags_r[UIF_B_ACTV]) |=> flags_r[UIF_B_ACTV])
    else $error("activity cleared while suspended");
  a_trn_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (run && ev_trn && w_flags && !pwdata[UIF_B_TRN]) |=> flags_r[UIF_B_TRN])
    else $error("event lost against clear");
  a_queue_pops: assert property (@(posedge pclk) disable iff (!presetn)
    queue_advance |=> !flags_r[UIF_B_TRN])
    else $error("queue advanced but done flag kept");
  a_line_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (armed_r && (&prime_r) && (dm_s != dm_d_r)) |=> flags_r[UIF_B_ACTV])
    else $error("line edge missed");

endmodule

// ===== uif_irq_ctl_model.sv
// model of the processor interrupt controller behind the funnel request
// assumes the pclk domain and an active-low asynchronous reset
`timescale 1ns/1ps
module uif_irq_ctl_model
  import uif_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request from the funnel
  input  wire logic       usb_combined_irq,
  // latched peripheral flags
  output logic      [7:0] peripheral_flag_reg2
);
  // ----------------------------------------
  // flag latch
  // ----------------------------------------
  // sticky until reset: no handler clears it here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_flag_reg2 <= 8'h00;
    end else if (usb_combined_irq) begin
      peripheral_flag_reg2[UIF_IRQ_BIT] <= 1'b1;
    end
  end
endmodule

// ===== usb_interrupt_status_funnel_tb_top.sv
// testbench for the usb interrupt status funnel
// assumes uif_pkg, uif_funnel and uif_irq_ctl_model are compiled first
`timescale 1ns/1ps
`define CHK(a, b, s) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t %s", $time, s); end end
module usb_interrupt_status_funnel_tb_top
  import uif_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] paddr      = 32'h0000_0000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [3:0]  ev         = 4'h0;
  logic [7:0]  ev_err     = 8'h00;
  logic        line_dp    = 1'b1;
  logic        line_dm    = 1'b0;
  logic        bus_idle   = 1'b0;
  logic        pll_locked = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        eclk;
  logic        qa;
  logic [6:0]  dev_addr;
  logic [7:0]  pfr2;
  logic [32:0] q_exp[$];
  logic [32:0] q_msk[$];
  logic [32:0] e;
  logic [32:0] m;
  logic [31:0] rs         = 32'h0000_0014;
  logic [31:0] r;
  logic [7:0]  exp;
  logic [6:0]  a7;
  int          n_fail     = 0;
  int          n_checks   = 0;
  int          n_qa       = 0;
  int          bp[4]      = '{UIF_B_SOF, UIF_B_STALL, UIF_B_TRN, UIF_B_RESET};

  uif_funnel dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev_sof(ev[0]), .ev_stall(ev[1]), .ev_trn(ev[2]), .ev_reset(ev[3]), .ev_err(ev_err),
    .line_dp(line_dp), .line_dm(line_dm), .bus_idle(bus_idle), .pll_locked(pll_locked),
    .usb_combined_irq(irq), .engine_clk_en(eclk), .queue_advance(qa),
    .device_address(dev_addr)
  );
  uif_irq_ctl_model fw_u (
    .pclk(pclk), .presetn(presetn), .usb_combined_irq(irq), .peripheral_flag_reg2(pfr2)
  );

  // ----------------------------------------
  // clock and monitors
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (qa === 1'b1) n_qa++;
  end
  // oldest note is matched against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q_exp.size() > 0) begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      `CHK({pslverr, prdata} & m, e & m, "read data")
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // events in ee ride the access phase so they land on the write edge
  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d,
                     input logic [3:0] ee, output logic [31:0] rd_v);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {18'h0_0000, a};
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    ev      <= ee;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      report_and_stop();
    end
    rd_v = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    ev      <= 4'h0;
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'h0, r);
  endtask
  task automatic rd(input logic [13:0] a, input logic [32:0] ex, input logic [32:0] mk);
    q_exp.push_back(ex);
    q_msk.push_back(mk);
    apb(1'b0, a, 8'h00, 4'h0, r);
  endtask
  task automatic rf(input logic [7:0] ex);
    rd(UIF_ADDR_FLAGS, {25'h000_0000, ex}, {33{1'b1}});
  endtask
  task automatic pulse(input logic [3:0] ee, input logic [7:0] er);
    @(posedge pclk);
    ev     <= ee;
    ev_err <= er;
    @(posedge pclk);
    ev     <= 4'h0;
    ev_err <= 8'h00;
    repeat (2) @(posedge pclk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(eclk, 1'b0, "engine runs unlocked")
    pll_locked <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK(eclk, 1'b1, "engine stopped")
    rf(8'h00);
    rd(UIF_ADDR_ENABLES, 33'h0_0000_0000, {33{1'b1}});
    rd(14'h0ff0, {1'b1, 32'h0000_0000}, {33{1'b1}});
    done("reset values");
    r  = xs();
    a7 = r[6:0];
    wr(UIF_ADDR_ADDRESS, {1'b0, a7});
    rd(UIF_ADDR_ADDRESS, {26'h000_0000, a7}, {33{1'b1}});
    exp = 8'h00;
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 8'h00);
      exp[bp[i]] = 1'b1;
      rf(exp);
    end
    `CHK(dev_addr, 7'h00, "address kept")
    wr(UIF_ADDR_FLAGS, 8'h61);
    rf(8'h61);
    `CHK(n_qa, 1, "queue advance")
    wr(UIF_ADDR_FLAGS, 8'hff);
    rf(8'h7d);
    wr(UIF_ADDR_FLAGS, 8'h00);
    rf(8'h00);
    apb(1'b1, UIF_ADDR_FLAGS, 8'h00, 4'h1, r);
    rf(8'h40);
    done("flags");
    wr(UIF_ADDR_ENABLES, 8'h40);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1, "request low")
    `CHK(pfr2[UIF_IRQ_BIT], 1'b1, "controller flag")
    wr(UIF_ADDR_ENABLES, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0, "request high")
    rf(8'h40);
    wr(UIF_ADDR_FLAGS, 8'h00);
    pulse(4'h0, 8'h04);
    rd(UIF_ADDR_ERRFLAGS, 33'h0_0000_0004, {33{1'b1}});
    rf(8'h00);
    wr(UIF_ADDR_ERRENS, 8'h01);
    pulse(4'h0, 8'h01);
    rf(8'h02);
    wr(UIF_ADDR_FLAGS, 8'h00);
    rf(8'h02);
    wr(UIF_ADDR_ERRFLAGS, 8'h00);
    rf(8'h00);
    done("enables and errors");
    bus_idle <= 1'b1;
    repeat (30020) @(posedge pclk);
    rf(8'h10);
    bus_idle <= 1'b0;
    wr(UIF_ADDR_ENABLES, 8'h04);
    wr(UIF_ADDR_CONTROL, 8'h02);
    repeat (2) @(posedge pclk);
    `CHK(eclk, 1'b0, "engine runs suspended")
    pulse(4'h1, 8'h00);
    line_dm <= ~line_dm;
    repeat (8) @(posedge pclk);
    rf(8'h14);
    `CHK(irq, 1'b1, "no activity request")
    wr(UIF_ADDR_FLAGS, 8'h10);
    rf(8'h14);
    wr(UIF_ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 20; i++) begin
      rd(UIF_ADDR_FLAGS, 33'h0_0000_0000, 33'h0_0000_0000);
      if (r[UIF_B_ACTV] !== 1'b1) break;
      wr(UIF_ADDR_FLAGS, 8'h10);
    end
    rf(8'h10);
    line_dp <= ~line_dp;
    repeat (8) @(posedge pclk);
    rf(8'h10);
    `CHK(irq, 1'b0, "second activity request")
    done("suspend and activity");
    report_and_stop();
  end
endmodule
